// ---- hdl/dic_defs.vh ----
// Offsets, field positions, reset values and timing counts for the data interface clocking block
`ifndef DIC_DEFS_VH
`define DIC_DEFS_VH
// Register offsets (byte addresses on the plain port)
`define DIC_ADDR_CLK_CONTROL 8'h20
`define DIC_ADDR_FORMAT 8'h21
`define DIC_ADDR_DIVIDER 8'h22
`define DIC_ADDR_PHASE 8'h23
`define DIC_ADDR_UPDATE 8'h24
// Field positions
`define DIC_BIT_INVERT 4
`define DIC_BIT_WIDTH 4
`define DIC_BIT_COMPLEX 3
`define DIC_LAT_MSB 2
`define DIC_LAT_LSB 0
`define DIC_DIV_MSB 6
`define DIC_DIV_LSB 4
`define DIC_SMP_MSB 7
`define DIC_SMP_LSB 4
`define DIC_SNC_MSB 3
`define DIC_SNC_LSB 0
`define DIC_BIT_UPDATE 7
// Fixed readback and reset values
`define DIC_FIXED_FIXED_READBACK_BITS 4'hF
`define DIC_RST_FORMAT 8'h00
`define DIC_RST_DIV 3'h0
`define DIC_RST_PHASE 8'h00
// Divider codes
`define DIC_DIV_OFF 3'h0
`define DIC_DIV_16 3'h1
`define DIC_DIV_32 3'h2
`define DIC_DIV_64 3'h4
// Half periods and last counts, in source clock cycles
`define DIC_HALF_16 6'h08
`define DIC_HALF_32 6'h10
`define DIC_HALF_64 6'h20
`define DIC_LAST_16 6'h0F
`define DIC_LAST_32 6'h1F
`define DIC_LAST_64 6'h3F
// Phase step shift: one sixteenth of the output period
`define DIC_SHIFT_16 2'h0
`define DIC_SHIFT_32 2'h1
`define DIC_SHIFT_64 2'h2
`endif

// ---- hdl/dic_top.v ----
// Data interface clocking: format control, output clock divider, phase select and frame-sync latency
//
// Contract
// - Word width bit picks 8 or 16 bits
// - Complex bit picks real or complex samples
// - Three-bit field sets frame-sync turnaround delay
// - Code n starts sampling at edge n+1
// - Divider codes: off, /16, /32, /64
// - Divider register low nibble reads 1111
// - Bits 7:4 select sampling clock phase
// - Each phase step delays one sixteenth period
// - Sync clock placed on one of sixteen phases
// - Divider and phase settings apply on update bit rise; invert takes effect on write
// - Invert bit drives output clock inverted
`timescale 1ns/1ns
`default_nettype none
`include "dic_defs.vh"

module dic_top #(
  parameter DATA_W = 16
) (
  input wire clock_i,
  input wire resetn_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output wire [7:0] reg_rdata_o,
  // Host link
  input wire frame_sync_i,
  input wire [DATA_W-1:0] sample_data_i,
  output wire data_clock_out_o,
  // Datapath side
  output wire word_width_select_o,
  output wire complex_select_o,
  output wire sampling_active_o,
  output wire sampling_clock_o,
  output wire datapath_sync_clock_o,
  output wire [DATA_W-1:0] sample_word_o,
  output wire sample_valid_o,
  output wire sample_is_q_o
);

  // Software visible registers
  reg invert_reg; // Output clock invert
  reg [7:0] format_reg; // Width, complex, latency
  reg [2:0] div_shadow_reg; // Divider code as written
  reg [7:0] phase_shadow_reg; // Phase codes as written
  reg update_reg; // Update bit readback
  reg [7:0] rdata_reg; // Read data, one cycle after strobe

  // Settings in force after an update
  reg [2:0] div_act_reg;
  reg [3:0] smp_phase_reg;
  reg [3:0] snc_phase_reg;

  // Divider state
  reg [5:0] cnt_reg; // Position inside one output period
  reg dco_reg; // Output clock flop
  reg en; // Divider running
  reg [5:0] half; // First count of the low half
  reg [5:0] last; // Last count of a period
  reg [1:0] shift; // Phase step size as a shift
  wire rise_evt; // Internal output clock rising edge
  wire [5:0] smp_pos; // Count where sampling clock fires
  wire [5:0] snc_pos; // Count where sync clock fires

  // Frame sync synchroniser and filter
  reg fs_s1_reg;
  reg fs_s2_reg;
  reg fs_s3_reg;
  reg fs_state_reg; // Filtered frame sync level
  reg [3:0] lat_cnt_reg; // Remaining edges before sampling
  reg active_reg; // Sampling running

  // Data pipeline, kept level with the frame sync path
  reg [DATA_W-1:0] d_s1_reg;
  reg [DATA_W-1:0] d_s2_reg;
  reg [DATA_W-1:0] d_s3_reg;

  // Datapath outputs
  reg smp_clk_reg;
  reg snc_clk_reg;
  reg [DATA_W-1:0] word_reg;
  reg valid_reg;
  reg is_q_reg;

  // Update strobe: write of a one while the readback bit is zero
  wire upd_write;
  wire upd_rise;
  assign upd_write = reg_write_i && (reg_addr_i == `DIC_ADDR_UPDATE);
  assign upd_rise = upd_write && reg_wdata_i[`DIC_BIT_UPDATE] && !update_reg;

  // Register writes
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      invert_reg <= 1'b0;
      format_reg <= `DIC_RST_FORMAT;
      div_shadow_reg <= `DIC_RST_DIV;
      phase_shadow_reg <= `DIC_RST_PHASE;
    end
    else if (reg_write_i)
    begin
      case (reg_addr_i)
        `DIC_ADDR_CLK_CONTROL: invert_reg <= reg_wdata_i[`DIC_BIT_INVERT];
        // Only the width, complex and latency bits live here
        `DIC_ADDR_FORMAT: format_reg <= {3'h0, reg_wdata_i[4:0]};
        // Held in shadow until the update bit rises
        `DIC_ADDR_DIVIDER: div_shadow_reg <= reg_wdata_i[`DIC_DIV_MSB:`DIC_DIV_LSB];
        `DIC_ADDR_PHASE: phase_shadow_reg <= reg_wdata_i;
        default:
        begin
          // Update address is handled in the next block; other addresses are not mapped; writes are dropped
        end
      endcase
    end
  end

  // Update bit and the settings in force
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      update_reg <= 1'b0;
      div_act_reg <= `DIC_RST_DIV;
      smp_phase_reg <= 4'h0;
      snc_phase_reg <= 4'h0;
    end
    else if (upd_rise)
    begin
      // Applied at once, so readback shows one in the next read
      update_reg <= 1'b1;
      div_act_reg <= div_shadow_reg;
      smp_phase_reg <= phase_shadow_reg[`DIC_SMP_MSB:`DIC_SMP_LSB];
      snc_phase_reg <= phase_shadow_reg[`DIC_SNC_MSB:`DIC_SNC_LSB];
    end
    else if (upd_write && !reg_wdata_i[`DIC_BIT_UPDATE])
    begin
      // Writing zero re-arms the next update
      update_reg <= 1'b0;
    end
  end

  // Register reads, answered in the following cycle only
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      rdata_reg <= 8'h00;
    end
    else if (reg_read_i)
    begin
      case (reg_addr_i)
        `DIC_ADDR_CLK_CONTROL: rdata_reg <= {3'h0, invert_reg, 4'h0};
        `DIC_ADDR_FORMAT: rdata_reg <= format_reg;
        // Low nibble is wired to fixed_readback_bits whatever was written
        `DIC_ADDR_DIVIDER: rdata_reg <= {1'b0, div_shadow_reg, `DIC_FIXED_FIXED_READBACK_BITS};
        `DIC_ADDR_PHASE: rdata_reg <= phase_shadow_reg;
        `DIC_ADDR_UPDATE: rdata_reg <= {update_reg, 7'h00};
        // Unmapped addresses read as zero
        default: rdata_reg <= 8'h00;
      endcase
    end
    else
    begin
      // Data stand for one cycle only
      rdata_reg <= 8'h00;
    end
  end

  // Divider decode; invalid codes are treated as off so the pin stays quiet
  always @*
  begin
    en = 1'b1;
    half = `DIC_HALF_16;
    last = `DIC_LAST_16;
    shift = `DIC_SHIFT_16;
    case (div_act_reg)
      `DIC_DIV_16:
      begin
        half = `DIC_HALF_16;
        last = `DIC_LAST_16;
        shift = `DIC_SHIFT_16;
      end
      `DIC_DIV_32:
      begin
        half = `DIC_HALF_32;
        last = `DIC_LAST_32;
        shift = `DIC_SHIFT_32;
      end
      `DIC_DIV_64:
      begin
        half = `DIC_HALF_64;
        last = `DIC_LAST_64;
        shift = `DIC_SHIFT_64;
      end
      // Off and the codes the host must not use
      default: en = 1'b0;
    endcase
  end

  // The period is sixteen phase steps, so a step is period / 16 cycles
  assign smp_pos = {2'h0, smp_phase_reg} << shift;
  assign snc_pos = {2'h0, snc_phase_reg} << shift;
  assign rise_evt = en && (cnt_reg == 6'h00);

  // Period counter; restarts on an update so the new rate starts clean
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      cnt_reg <= 6'h00;
    end
    else if (upd_rise || !en || (cnt_reg >= last))
    begin
      cnt_reg <= 6'h00;
    end
    else
    begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // Output clock: high half first, then low; static when stopped
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      dco_reg <= 1'b0;
    end
    else if (en)
    begin
      dco_reg <= (cnt_reg < half) ^ invert_reg;
    end
    else
    begin
      // Holding the idle level keeps the host from seeing edges
      dco_reg <= invert_reg;
    end
  end

  // Frame sync: three flops, a change counts when the last two agree;
  // data take the same three stages so they line up with frame sync
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      fs_s1_reg <= 1'b0;
      fs_s2_reg <= 1'b0;
      fs_s3_reg <= 1'b0;
      fs_state_reg <= 1'b0;
      d_s1_reg <= {DATA_W{1'b0}};
      d_s2_reg <= {DATA_W{1'b0}};
      d_s3_reg <= {DATA_W{1'b0}};
    end
    else
    begin
      fs_s1_reg <= frame_sync_i;
      fs_s2_reg <= fs_s1_reg;
      fs_s3_reg <= fs_s2_reg;
      d_s1_reg <= sample_data_i;
      d_s2_reg <= d_s1_reg;
      d_s3_reg <= d_s2_reg;
      if (fs_s2_reg == fs_s3_reg)
      begin
        fs_state_reg <= fs_s3_reg;
      end
    end
  end

  // Latency: count output clock rises after frame sync falls
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      lat_cnt_reg <= 4'h0;
      active_reg <= 1'b0;
    end
    else if (fs_state_reg)
    begin
      // Frame sync high: stop and wait for its fall
      lat_cnt_reg <= {1'b0, format_reg[`DIC_LAT_MSB:`DIC_LAT_LSB]} + 4'h1;
      active_reg <= 1'b0;
    end
    else if (rise_evt && (lat_cnt_reg != 4'h0))
    begin
      lat_cnt_reg <= lat_cnt_reg - 4'h1;
      if (lat_cnt_reg == 4'h1)
      begin
        // Edge n+1 reached; sampling begins
        active_reg <= 1'b1;
      end
    end
  end

  // Phase-placed sampling and sync clocks, one pulse per period
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      smp_clk_reg <= 1'b0;
      snc_clk_reg <= 1'b0;
    end
    else
    begin
      smp_clk_reg <= en && (cnt_reg == smp_pos);
      snc_clk_reg <= en && (cnt_reg == snc_pos);
    end
  end

  // Sample capture on the sampling phase while active
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      word_reg <= {DATA_W{1'b0}};
      valid_reg <= 1'b0;
      is_q_reg <= 1'b0;
    end
    else if (active_reg && en && (cnt_reg == smp_pos))
    begin
      valid_reg <= 1'b1;
      if (format_reg[`DIC_BIT_WIDTH])
      begin
        word_reg <= d_s3_reg;
      end
      else
      begin
        // Narrow words: upper bits forced to zero
        word_reg <= {{(DATA_W-8){1'b0}}, d_s3_reg[7:0]};
      end
      // Complex samples alternate I then Q; real fixed_readback_bits are all I
      is_q_reg <= format_reg[`DIC_BIT_COMPLEX] && valid_reg && !is_q_reg;
    end
    else
    begin
      if (!active_reg)
      begin
        // A new frame always opens on I
        is_q_reg <= 1'b0;
        valid_reg <= 1'b0;
      end
    end
  end

  // Output wiring; every output is a flop
  assign reg_rdata_o = rdata_reg;
  assign data_clock_out_o = dco_reg;
  assign word_width_select_o = format_reg[`DIC_BIT_WIDTH];
  assign complex_select_o = format_reg[`DIC_BIT_COMPLEX];
  assign sampling_active_o = active_reg;
  assign sampling_clock_o = smp_clk_reg;
  assign datapath_sync_clock_o = snc_clk_reg;
  assign sample_word_o = word_reg;
  assign sample_valid_o = valid_reg;
  assign sample_is_q_o = is_q_reg;

endmodule
`default_nettype wire

// ---- tb/data_interface_clocking_test.sv ----
// Self-checking bench for the data interface clocking block
`timescale 1ns/1ns
`default_nettype none
module data_interface_clocking_test;
  logic clock_i, resetn_i, reg_write_i, reg_read_i, frame_sync_i, frame_req, pv;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
  logic [15:0] sample_data_i, sample_word_o;
  logic data_clock_out_o, word_width_select_o, complex_select_o, sampling_active_o;
  logic sampling_clock_o, datapath_sync_clock_o, sample_valid_o, sample_is_q_o;
  int num_errors = 0, check_count = 0, n, m, c;
  typedef struct { logic [7:0] a, d, rb; logic ww, cs; } dic_row_t;
  // Address, write data, readback, width and complex outputs after the write
  dic_row_t rows [8] = '{'{8'h21, 8'h18, 8'h18, 1, 1}, '{8'h21, 8'hFF, 8'h1F, 1, 1},
    '{8'h21, 8'h08, 8'h08, 0, 1}, '{8'h21, 8'h10, 8'h10, 1, 0}, '{8'h22, 8'h9C, 8'h1F, 1, 0},
    '{8'h22, 8'h4F, 8'h4F, 1, 0}, '{8'h23, 8'hA5, 8'hA5, 1, 0}, '{8'h30, 8'hFF, 8'h00, 1, 0}};
  dic_top i_dut (.*);
  dic_host_model i_host (.dco_i(data_clock_out_o), .frame_req_i(frame_req), .frame_sync_o(frame_sync_i),
    .sample_data_o(sample_data_i));
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Single-cycle strobes launched just after an edge
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clock_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1 r = reg_rdata_o;
  endtask
  // Bounded wait step; running out ends the run as a failure
  task automatic step(inout int k);
    @(negedge clock_i);
    k++;
    if (k > 1000)
    begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic to_rise(output int k);
    k = 0;
    while (data_clock_out_o !== 1'b0) step(k);
    while (data_clock_out_o !== 1'b1) step(k);
  endtask
  initial
  begin
    resetn_i = 1'b0;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    frame_req = 1'b0;
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rd(8'h21 + 8'(i), q);
      check(q, i == 1 ? 8'h0F : 8'h00);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      check(q, rows[i].rb);
      check({word_width_select_o, complex_select_o}, {rows[i].ww, rows[i].cs});
    end
    // Divider held off until the update bit rises
    wr(8'h22, 8'h10);
    repeat (40) @(posedge clock_i);
    check(data_clock_out_o, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h22, 8'h10 << k);
      wr(8'h23, 8'h35);
      wr(8'h24, 8'h00);
      wr(8'h24, 8'h80);
      rd(8'h24, q);
      check(q[7], 1'b1);
      to_rise(n);
      to_rise(n);
      check(16'(n), 16'(16 << k));
      m = 0;
      while (sampling_clock_o !== 1'b1) step(m);
      check(16'(m), 16'(3 << k));
      to_rise(n);
      m = 0;
      while (datapath_sync_clock_o !== 1'b1) step(m);
      check(16'(m), 16'(5 << k));
    end
    // Shortest and longest latency codes, counted in output clock rises
    for (int lat = 0; lat < 8; lat += 7)
    begin
      wr(8'h21, 8'(lat));
      @(posedge clock_i);
      frame_req <= 1'b1;
      to_rise(n);
      to_rise(n);
      @(posedge clock_i);
      frame_req <= 1'b0;
      n = 0;
      while (frame_sync_i !== 1'b0) step(n);
      c = 0;
      pv = data_clock_out_o;
      while (sampling_active_o !== 1'b1)
      begin
        step(n);
        c += int'(data_clock_out_o && !pv);
        pv = data_clock_out_o;
      end
      check(16'(c), 16'(lat + 1));
      repeat (200) @(negedge clock_i);
      check(sample_valid_o, 1'b1);
      check(sample_word_o[15:8], 8'h00);
      check(sample_is_q_o, 1'b0);
      @(posedge clock_i);
      frame_req <= 1'b1;
      to_rise(n);
      to_rise(n);
      repeat (8) @(posedge clock_i);
      check(sampling_active_o, 1'b0);
    end
    // Wide complex words: the first word of a frame is I, then Q, then I
    wr(8'h21, 8'h18);
    @(posedge clock_i);
    frame_req <= 1'b0;
    n = 0;
    while (sample_valid_o !== 1'b1) step(n);
    check(sample_is_q_o, 1'b0);
    check(16'(sample_word_o[15:8] != 8'h00), 16'h0001);
    for (int w = 1; w < 3; w++)
    begin
      while (sampling_clock_o !== 1'b0) step(n);
      while (sampling_clock_o !== 1'b1) step(n);
      check(sample_is_q_o, 16'(w % 2));
    end
    // Stop the divider in its low half so the host never sees a short high pulse
    wr(8'h22, 8'h00);
    wr(8'h24, 8'h00);
    to_rise(n);
    repeat (36) @(posedge clock_i);
    wr(8'h24, 8'h80);
    repeat (70) @(posedge clock_i);
    check(data_clock_out_o, 1'b0);
    wr(8'h20, 8'h10);
    repeat (10) @(posedge clock_i);
    check(data_clock_out_o, 1'b1);
    repeat (30) @(posedge clock_i);
    check(data_clock_out_o, 1'b1);
    // Reset in mid-run brings registers and outputs back to their idle values
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(8'h20, q);
    check(q, 8'h00);
    rd(8'h22, q);
    check(q, 8'h0F);
    check({data_clock_out_o, sampling_active_o, sample_valid_o}, 3'h0);
    check({word_width_select_o, complex_select_o}, 2'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- tb/dic_host_model.sv ----
// Host model: frame sync and counting samples clocked by the output clock
`timescale 1ns/1ns
`default_nettype none
module dic_host_model (
  input wire logic dco_i,
  input wire logic frame_req_i,
  output logic frame_sync_o,
  output logic [15:0] sample_data_o
);
  // Data counts in both bytes so a dropped upper byte shows
  initial
  begin
    frame_sync_o = 1'b0;
    sample_data_o = 16'h0100;
  end
  // Host changes only on the rising output clock edge, as real host logic would
  always @(posedge dco_i)
  begin
    frame_sync_o <= frame_req_i;
    sample_data_o <= sample_data_o + 16'h0101;
  end
endmodule
`default_nettype wire

// ---- tb/dic_properties.sv ----
// Checker for the data interface clocking block
`timescale 1ns/1ns
`default_nettype none
module dic_properties #(
  parameter DATA_W = 16
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic frame_sync_i,
  input wire logic data_clock_out_o,
  input wire logic word_width_select_o,
  input wire logic complex_select_o,
  input wire logic sampling_active_o,
  input wire logic sampling_clock_o,
  input wire logic datapath_sync_clock_o,
  input wire logic [DATA_W-1:0] sample_word_o,
  input wire logic sample_valid_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  a_rdata_rest: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside its cycle");
  a_fixed_fixed_readback_bits: assert property ($past(reg_read_i && reg_addr_i == 8'h22) |-> reg_rdata_o[3:0] == 4'hF)
    else $error("divider low bits not fixed_readback_bits");
  a_width_follow: assert property (reg_write_i && reg_addr_i == 8'h21
    |=> word_width_select_o == $past(reg_wdata_i[4]))
    else $error("word width not taken");
  a_complex_select_follow: assert property (reg_write_i && reg_addr_i == 8'h21
    |=> complex_select_o == $past(reg_wdata_i[3]))
    else $error("complex select not taken");
  // Shortest half period of any valid divider is eight cycles
  a_clock_half: assert property ($rose(data_clock_out_o) |=> $stable(data_clock_out_o) [*7])
    else $error("output clock high too short");
  a_sync_stops: assert property (frame_sync_i [*7] |-> !sampling_active_o)
    else $error("sampling active during frame sync");
  a_valid_clear: assert property (!sampling_active_o [*2] |-> !sample_valid_o)
    else $error("valid while not sampling");
  a_valid_cause: assert property ($rose(sample_valid_o) |-> $past(sampling_active_o))
    else $error("valid without sampling");
  a_narrow_word: assert property (sample_valid_o && !word_width_select_o && $past(!word_width_select_o)
    |-> sample_word_o[DATA_W-1:8] == '0)
    else $error("upper byte set in narrow mode");
  a_update_seen: assert property ((reg_write_i && reg_addr_i == 8'h24 && reg_wdata_i[7]) ##2
    (reg_read_i && reg_addr_i == 8'h24) |=> reg_rdata_o[7])
    else $error("update bit not read back");
  c_active: cover property ($rose(sampling_active_o));
  c_valid: cover property ($rose(sample_valid_o));
  c_strobe: cover property (sampling_clock_o);
endmodule
bind dic_top dic_properties #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire
